// File: asce_cfg.svh
/*
 * Constants of the serial command engine: opcodes, field positions,
 * widths and timing counts. Assumes a 20 MHz core clock.
 */
`ifndef ASCE_CFG_SVH
`define ASCE_CFG_SVH

`define ASCE_OP_START        8'h08
`define ASCE_OP_STOP         8'h0a
`define ASCE_OP_CONT_READ    8'h10
`define ASCE_OP_HALT_CONT    8'h11
`define ASCE_OP_READ_DATA    8'h12
`define ASCE_OP_STOP_7B      7'h05
`define ASCE_OP_READ_DATA_7B 7'h09
`define ASCE_GRP_REG_READ    3'h1
`define ASCE_GRP_REG_WRITE   3'h2
`define ASCE_GRP_MSB         7
`define ASCE_GRP_LSB         5
`define ASCE_FIELD_MSB       4
`define ASCE_REG_COUNT       32
`define ASCE_RESULT_BITS     216
`define ASCE_RESET_CONT      1'b1
`define ASCE_REG_RESET       8'h00
`define ASCE_BYTE_DECODE_GAP_TCLK 4
`define ASCE_UPDATE_TCLK     4
`define ASCE_UPDATE_CYCLES   (`ASCE_UPDATE_TCLK)

`endif

// File: asce_pkg.sv
/*
 * Types of the serial command engine.
 * Assumes asce_cfg.svh sits in the include path.
 */
package asce_pkg;
    typedef enum logic [2:0] {
        ASCE_CMD,
        ASCE_RD_CNT,
        ASCE_RD_DATA,
        ASCE_WR_CNT,
        ASCE_WR_DATA
    } asce_state_e;
    typedef logic [7:0] asce_byte_t;
endpackage : asce_pkg

// File: asce_command_engine.sv
/*
 * Serial command engine of a sampling converter: byte opcodes arrive on
 * a serial link, results and register bytes leave on it.
 * Assumes the host keeps the byte decode gap, so words held in the core
 * domain are stable whenever the link samples them.
 */
`timescale 1ns/1ps
`include "asce_cfg.svh"

// Summary of operation
// - stop opcode halts after current conversion, ignored in continuous mode
// - continuous mode presents each new result
// - continuous read mode after reset
// - idle output mirrors ready in continuous mode
// - halt opcode leaves continuous read mode
// - read opcode returns result, no wait
// - overlapping read keeps its snapshot intact
// - bytes spaced by four core periods
// - register read header, consecutive bytes back
// - first register MSB on 17th rising edge
// - register write header, consecutive bytes in, ignored in continuous mode
// - short opcodes at 7th, others 8th edge
// - opcode encodings 08, 0a, 10, 11, 12
// - register read ignored in continuous mode
module asce_command_engine
    import asce_pkg::*;
(
    input  wire logic                          I_CORE_CLK,
    input  wire logic                          I_RST_N,
    input  wire logic                          I_CE,
    input  wire logic                          I_SCLK,
    input  wire logic                          I_CS_N,
    input  wire logic                          I_DIN,
    output logic                               O_DOUT,
    input  wire logic                          I_START_PIN,
    input  wire logic                          I_CONV_BUSY,
    input  wire logic                          I_CONV_DONE,
    input  wire logic [`ASCE_RESULT_BITS-1:0]  I_CONV_DATA,
    output logic                               O_CONV_RUN,
    output logic                               O_RESULT_READY_N,
    output logic                               O_CONT_MODE
);
    localparam int RB = `ASCE_RESULT_BITS;

    // core domain
    asce_state_e    state_reg;
    logic [4:0]     addr_reg;
    logic [4:0]     cnt_reg;
    asce_byte_t     regs [`ASCE_REG_COUNT];
    asce_byte_t     tx_byte_reg;
    logic           cont_reg;
    logic           run_reg;
    logic           stop_pend_reg;
    logic           result_ready_n_n_reg;
    logic [2:0]     upd_cnt_reg;
    logic [RB-1:0]  result_reg;
    logic [1:0]     start_sync_reg;
    logic [2:0]     rx_sync_reg;
    logic [2:0]     rd_sync_reg;
    logic           rx_evt;
    logic           rd_evt;

    // link domain
    logic           lnk_rst_n;
    logic [2:0]     bit_cnt_reg;
    logic [6:0]     rx_sh_reg;
    asce_byte_t     rx_byte_reg;
    logic           rx_tgl_reg;
    logic           early_reg;
    logic           rdata_go_reg;
    logic [RB-1:0]  tx_sh_reg;
    logic           loaded_reg;
    logic           shifting_reg;
    logic           rd_tgl_reg;
    logic [6:0]     rx_7b;

    // frame end clears the link side except the byte word and the two toggles; sclk may stop between frames
    assign lnk_rst_n = I_RST_N & ~I_CS_N;
    assign rx_7b     = {rx_sh_reg[5:0], I_DIN};

    // sample din on falling sclk
    always_ff @(negedge I_SCLK or negedge lnk_rst_n) begin
        if (!lnk_rst_n) begin
            bit_cnt_reg <= 3'h0;
            rx_sh_reg   <= 7'h00;
            early_reg   <= 1'b0;
        end else begin
            rx_sh_reg   <= rx_7b;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
                early_reg <= 1'b0;
            end else if (bit_cnt_reg == 3'h6 && state_reg == ASCE_CMD &&
                         (rx_7b == `ASCE_OP_STOP_7B ||
                          rx_7b == `ASCE_OP_READ_DATA_7B)) begin
                early_reg <= 1'b1;
            end
        end
    end

    // byte word and its event toggle live across frames
    always_ff @(negedge I_SCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rx_byte_reg <= 8'h00;
            rx_tgl_reg  <= 1'b0;
        end else if (I_CS_N) begin
            rx_tgl_reg  <= rx_tgl_reg;
        end else if (bit_cnt_reg == 3'h6 && state_reg == ASCE_CMD &&
                     (rx_7b == `ASCE_OP_STOP_7B ||
                      rx_7b == `ASCE_OP_READ_DATA_7B)) begin
            rx_byte_reg <= {rx_7b, 1'b0};
            rx_tgl_reg  <= ~rx_tgl_reg;
        end else if (bit_cnt_reg == 3'h7 && !early_reg) begin
            rx_byte_reg <= {rx_sh_reg, I_DIN};
            rx_tgl_reg  <= ~rx_tgl_reg;
        end
    end

    // read-by-command arms the result load locally: no decode wait needed
    always_ff @(negedge I_SCLK or negedge lnk_rst_n) begin
        if (!lnk_rst_n) begin
            rdata_go_reg <= 1'b0;
        end else if (bit_cnt_reg == 3'h6 && state_reg == ASCE_CMD &&
                     !cont_reg && rx_7b == `ASCE_OP_READ_DATA_7B) begin
            rdata_go_reg <= 1'b1;
        end
    end

    // drive dout on rising sclk
    always_ff @(posedge I_SCLK or negedge lnk_rst_n) begin
        if (!lnk_rst_n) begin
            tx_sh_reg    <= '0;
            loaded_reg   <= 1'b0;
            shifting_reg <= 1'b0;
        end else begin
            shifting_reg <= 1'b1;
            if (bit_cnt_reg == 3'h0 && state_reg == ASCE_RD_DATA) begin
                tx_sh_reg <= {tx_byte_reg, {(RB-8){1'b0}}};
            end else if (bit_cnt_reg == 3'h0 && !loaded_reg &&
                         (cont_reg || rdata_go_reg)) begin
                tx_sh_reg  <= result_reg;
                loaded_reg <= 1'b1;
            end else begin
                tx_sh_reg <= {tx_sh_reg[RB-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge I_SCLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rd_tgl_reg <= 1'b0;
        end else if (!I_CS_N && bit_cnt_reg == 3'h0 && !loaded_reg &&
                     state_reg != ASCE_RD_DATA && (cont_reg || rdata_go_reg)) begin
            rd_tgl_reg <= ~rd_tgl_reg;
        end
    end

    // idle line mirrors result ready while in continuous mode
    assign O_DOUT = shifting_reg ? tx_sh_reg[RB-1] :
                    (cont_reg & result_ready_n_n_reg);

    // crossings into the core clock
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rx_sync_reg    <= 3'h0;
            rd_sync_reg    <= 3'h0;
            start_sync_reg <= 2'h0;
        end else if (I_CE) begin
            rx_sync_reg    <= {rx_sync_reg[1:0], rx_tgl_reg};
            rd_sync_reg    <= {rd_sync_reg[1:0], rd_tgl_reg};
            start_sync_reg <= {start_sync_reg[0], I_START_PIN};
        end
    end

    // edge detect looks only at the second and third stage
    assign rx_evt = I_CE & (rx_sync_reg[2] ^ rx_sync_reg[1]);
    assign rd_evt = I_CE & (rd_sync_reg[2] ^ rd_sync_reg[1]);

    // command decode and multi-byte sequencing
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_reg   <= ASCE_CMD;
            addr_reg    <= 5'h00;
            cnt_reg     <= 5'h00;
            tx_byte_reg <= 8'h00;
        end else if (rx_evt) begin
            case (state_reg)
                ASCE_CMD: begin
                    addr_reg <= rx_byte_reg[`ASCE_FIELD_MSB:0];
                    if (rx_byte_reg[`ASCE_GRP_MSB:`ASCE_GRP_LSB] ==
                        `ASCE_GRP_REG_READ && !cont_reg) begin
                        state_reg <= ASCE_RD_CNT;
                    end else if (rx_byte_reg[`ASCE_GRP_MSB:`ASCE_GRP_LSB] ==
                                 `ASCE_GRP_REG_WRITE && !cont_reg) begin
                        state_reg <= ASCE_WR_CNT;
                    end
                end
                ASCE_RD_CNT: begin
                    cnt_reg     <= rx_byte_reg[`ASCE_FIELD_MSB:0];
                    tx_byte_reg <= regs[addr_reg];
                    state_reg   <= ASCE_RD_DATA;
                end
                ASCE_RD_DATA: begin
                    addr_reg    <= addr_reg + 5'h01;
                    tx_byte_reg <= regs[addr_reg + 5'h01];
                    cnt_reg     <= cnt_reg - 5'h01;
                    if (cnt_reg == 5'h00) begin
                        state_reg <= ASCE_CMD;
                    end
                end
                ASCE_WR_CNT: begin
                    cnt_reg   <= rx_byte_reg[`ASCE_FIELD_MSB:0];
                    state_reg <= ASCE_WR_DATA;
                end
                ASCE_WR_DATA: begin
                    addr_reg <= addr_reg + 5'h01;
                    cnt_reg  <= cnt_reg - 5'h01;
                    if (cnt_reg == 5'h00) begin
                        state_reg <= ASCE_CMD;
                    end
                end
                default: begin
                    state_reg <= ASCE_CMD;
                end
            endcase
        end
    end

    // configuration bytes
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            for (int i = 0; i < `ASCE_REG_COUNT; i++) begin
                regs[i] <= `ASCE_REG_RESET;
            end
        end else if (rx_evt && state_reg == ASCE_WR_DATA) begin
            regs[addr_reg] <= rx_byte_reg;
        end
    end

    // read mode: only halt leaves continuous read, unknown bytes dropped
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cont_reg <= `ASCE_RESET_CONT;
        end else if (rx_evt && state_reg == ASCE_CMD) begin
            if (rx_byte_reg == `ASCE_OP_HALT_CONT) begin
                cont_reg <= 1'b0;
            end else if (rx_byte_reg == `ASCE_OP_CONT_READ) begin
                cont_reg <= 1'b1;
            end
        end
    end

    // stop lets the conversion under way finish first
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            run_reg       <= 1'b0;
            stop_pend_reg <= 1'b0;
        end else if (I_CE) begin
            if (rx_evt && state_reg == ASCE_CMD && !cont_reg &&
                rx_byte_reg == `ASCE_OP_START) begin
                run_reg       <= 1'b1;
                stop_pend_reg <= 1'b0;
            end else if (rx_evt && state_reg == ASCE_CMD && !cont_reg &&
                         rx_byte_reg == `ASCE_OP_STOP && run_reg) begin
                stop_pend_reg <= 1'b1;
            end else if (stop_pend_reg && (I_CONV_DONE || !I_CONV_BUSY)) begin
                run_reg       <= 1'b0;
                stop_pend_reg <= 1'b0;
            end
        end
    end

    // new result: ready stays high through the update window, then drops
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            upd_cnt_reg <= 3'h0;
            result_ready_n_n_reg  <= 1'b1;
            result_reg  <= '0;
        end else if (I_CE) begin
            if (I_CONV_DONE) begin
                result_reg  <= I_CONV_DATA;
                upd_cnt_reg <= 3'(`ASCE_UPDATE_CYCLES);
                result_ready_n_n_reg  <= 1'b1;
            end else if (upd_cnt_reg != 3'h0) begin
                upd_cnt_reg <= upd_cnt_reg - 3'h1;
                if (upd_cnt_reg == 3'h1) begin
                    result_ready_n_n_reg <= 1'b0;
                end
            end else if (rd_evt) begin
                result_ready_n_n_reg <= 1'b1;
            end
        end
    end

    assign O_CONV_RUN       = run_reg | start_sync_reg[1];
    assign O_RESULT_READY_N = result_ready_n_n_reg;
    assign O_CONT_MODE      = cont_reg;

endmodule : asce_command_engine

// File: asce_host_model.sv
/* Host model of the serial link: select, serial clock and data in.
   Assumes dout changes on rising clock edges and is read on falling ones. */
`timescale 1ns/1ps
module asce_host_model (
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_din,
    input  wire logic i_dout
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_din  = 1'b1;
    end
    // clock stands still between bytes and frames
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        o_cs_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #62.5 o_sclk = 1'b1;
            o_din = tx[i];
            #62.5 o_sclk = 1'b0;
            rx[i] = i_dout;
        end
        // decode gap; released line shows no stale value
        #400 o_din = ~o_din;
    endtask : xfer
    task automatic end_frame();
        o_cs_n = 1'b1;
        #500;
    endtask : end_frame
endmodule : asce_host_model

// File: asce_command_engine_assertions.sv
/* Checker of the command engine's core-side port behaviour.
   Assumes it is bound to asce_command_engine; core clock domain only. */
`timescale 1ns/1ps
module asce_chk (
    input wire logic I_CORE_CLK,
    input wire logic I_RST_N,
    input wire logic I_CS_N,
    input wire logic I_START_PIN,
    input wire logic I_CONV_BUSY,
    input wire logic I_CONV_DONE,
    input wire logic O_DOUT,
    input wire logic O_CONV_RUN,
    input wire logic O_RESULT_READY_N,
    input wire logic O_CONT_MODE
);
    logic [3:0] idle_reg;
    // bytes land in the core a few edges after select rises
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N)
            idle_reg <= 4'h0;
        else if (!I_CS_N)
            idle_reg <= 4'h0;
        else if (idle_reg != 4'hf)
            idle_reg <= idle_reg + 4'h1;
    end
    default clocking @(posedge I_CORE_CLK);
    endclocking
    default disable iff (!I_RST_N);
    property p_reset_mode;
        $rose(I_RST_N) |-> O_CONT_MODE && O_RESULT_READY_N;
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("bad reset mode");
    property p_ready_hold;
        I_CONV_DONE |=> O_RESULT_READY_N [*4];
    endproperty
    a_ready_hold: assert property (p_ready_hold) else $error("ready early");
    property p_ready_fall;
        I_CONV_DONE && I_CS_N |-> ##[4:6] !O_RESULT_READY_N;
    endproperty
    a_ready_fall: assert property (p_ready_fall) else $error("ready late");
    property p_ready_rise;
        $rose(O_RESULT_READY_N) |-> $past(I_CONV_DONE) || idle_reg < 4'h8;
    endproperty
    a_ready_rise: assert property (p_ready_rise) else $error("ready rose");
    property p_dout_mirror;
        I_CS_N |-> O_DOUT == (O_CONT_MODE && O_RESULT_READY_N);
    endproperty
    a_dout_mirror: assert property (p_dout_mirror) else $error("dout idle");
    property p_stop_finish;
        $fell(O_CONV_RUN) |-> !$past(I_CONV_BUSY) || $past(I_CONV_DONE);
    endproperty
    a_stop_finish: assert property (p_stop_finish) else $error("stop cut");
    property p_mode_cmd;
        $changed(O_CONT_MODE) |-> idle_reg < 4'h8;
    endproperty
    a_mode_cmd: assert property (p_mode_cmd) else $error("mode moved");
    property p_run_cmd;
        $rose(O_CONV_RUN) |-> idle_reg < 4'h8 || $past(I_START_PIN, 2);
    endproperty
    a_run_cmd: assert property (p_run_cmd) else $error("run rose");
endmodule : asce_chk
bind asce_command_engine asce_chk u_chk (
    .I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_CS_N(I_CS_N),
    .I_START_PIN(I_START_PIN), .I_CONV_BUSY(I_CONV_BUSY), .I_CONV_DONE(I_CONV_DONE),
    .O_DOUT(O_DOUT), .O_CONV_RUN(O_CONV_RUN), .O_RESULT_READY_N(O_RESULT_READY_N),
    .O_CONT_MODE(O_CONT_MODE));

// File: asce_command_engine_bench.sv
/* Self-checking bench of the serial command engine with a host model.
   Assumes the design, package and host model are compiled first. */
`timescale 1ns/1ps
`include "asce_cfg.svh"
module asce_command_engine_bench;
    import asce_pkg::*;
    typedef struct packed {logic [7:0] op; logic [1:0] mr;} asce_row_s;
    logic                         clk   = 1'b0;
    logic                         rst_n;
    logic                         pin   = 1'b0;
    logic                         busy  = 1'b0;
    logic                         cdone = 1'b0;
    logic [`ASCE_RESULT_BITS-1:0] cdata = '0;
    logic                         sclk, cs_n, din, dout, run, rdy_n, cont;
    logic [7:0]                   rx;
    logic [15:0]                  w;
    int                           fail_count = 0;
    int                           compares = 0;
    // mode and run expected after each one-byte frame
    asce_row_s rows [6] = '{{8'h11, 2'b00}, {8'h08, 2'b01}, {8'hff, 2'b01},
                            {8'h0a, 2'b00}, {8'h10, 2'b10}, {8'h11, 2'b00}};
    always #25 clk = ~clk;
    asce_command_engine uut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_CE(1'b1),
        .I_SCLK(sclk), .I_CS_N(cs_n), .I_DIN(din), .O_DOUT(dout), .I_START_PIN(pin),
        .I_CONV_BUSY(busy), .I_CONV_DONE(cdone), .I_CONV_DATA(cdata),
        .O_CONV_RUN(run), .O_RESULT_READY_N(rdy_n), .O_CONT_MODE(cont));
    asce_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic conv(input logic [`ASCE_RESULT_BITS-1:0] d);
        @(posedge clk);
        cdata <= d;
        cdone <= 1'b1;
        busy  <= 1'b0;
        @(posedge clk);
        cdone <= 1'b0;
    endtask : conv
    task automatic cmd(input logic [7:0] op);
        host.xfer(op, rx);
        host.end_frame();
    endtask : cmd
    task automatic summarize();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize
    initial begin
        // assigned in the nba region so the reset edge is seen at time zero
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        cyc(2);
        foreach (rows[i]) begin
            cmd(rows[i].op);
            chk({cont, run}, rows[i].mr);
        end
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        cyc(2);
        chk({cont, rdy_n, dout}, 3'b111);
        conv({27{8'hc3}});
        cyc(8);
        chk({rdy_n, dout}, 2'b00);
        host.xfer(8'h00, w[15:8]);
        host.xfer(8'h00, w[7:0]);
        host.end_frame();
        chk(w, 16'hc3c3);
        chk({rdy_n, dout}, 2'b11);
        // register read header in continuous mode must be dropped
        host.xfer(8'h21, rx);
        host.xfer(8'h00, rx);
        host.end_frame();
        cmd(8'h11);
        chk({15'h0, cont}, 16'h0000);
        host.xfer(8'h42, rx);
        host.xfer(8'h01, rx);
        host.xfer(8'ha5, rx);
        host.xfer(8'h3c, rx);
        host.end_frame();
        host.xfer(8'h21, rx);
        host.xfer(8'h02, rx);
        host.xfer(8'h00, w[15:8]);
        host.xfer(8'h00, w[7:0]);
        chk(w, 16'h00a5);
        host.xfer(8'h00, rx);
        host.end_frame();
        chk({8'h00, rx}, 16'h003c);
        cmd(8'h08);
        @(posedge clk);
        busy <= 1'b1;
        cmd(8'h0a);
        chk({15'h0, run}, 16'h0001);
        conv({27{8'h5a}});
        cyc(2);
        chk({15'h0, run}, 16'h0000);
        // start pin path: two sync stages, then run follows the pin
        @(posedge clk);
        pin <= 1'b1;
        cyc(3);
        chk({15'h0, run}, 16'h0001);
        @(posedge clk);
        pin <= 1'b0;
        cyc(3);
        chk({15'h0, run}, 16'h0000);
        conv({27{8'h96}});
        cyc(8);
        host.xfer(8'h12, rx);
        host.xfer(8'h00, w[15:8]);
        conv({27{8'h69}});
        host.xfer(8'h00, w[7:0]);
        host.end_frame();
        chk(w, 16'h9696);
        summarize();
    end
    initial begin
        #200000;
        fail_count++;
        summarize();
    end
endmodule : asce_command_engine_bench
